//--- hw/fbpf_pkg.sv
// Purpose: shared constants for the flash protect and function register
// Assumes: 64 blocks of 64 KB, 8-bit registers
// Notes: none
package fbpf_pkg;
	// ==========================================
	// geometry
	localparam int BLK_W = 6;
	localparam logic [5:0] BLK_TOP = 6'h3F;
	localparam logic [5:0] BLK_BOT = 6'h00;
	// ==========================================
	// function register field positions
	localparam int FN_RST_DIS = 0;
	localparam int FN_RSVD = 1;
	localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
	localparam int FN_ERASE_SUSPENDED_FLAG = 3;
	localparam int FN_LOCK_LO = 4;
	// otp bits of the function register
	localparam logic [7:0] FN_OTP_MASK = 8'hF1;
	// ==========================================
	// reset values
	localparam logic [7:0] FN_RESET = 8'h00;
	localparam logic [7:0] RDPAR_RESET = 8'h00;
	localparam logic [3:0] CODE_RESET = 4'h0;
	// ==========================================
	// operation kinds on the request port
	typedef enum logic [1:0] {
		FBPF_OP_PROG,
		FBPF_OP_ERASE,
		FBPF_OP_CHIP,
		FBPF_OP_ROW
	} fbpf_op_t;
endpackage

//--- hw/fbpf_if.sv
// Purpose: carrier between the top and the protect decoder
// Assumes: single clock domain, combinational decode
// Notes: none
`timescale 1ns/10ps
interface fbpf_if;
	logic [3:0] code; // protect code
	logic [5:0] blk; // target block
	logic hit; // target lies in protected area
	modport top (output code, output blk, input hit);
	modport dec (input code, input blk, output hit);
endinterface

//--- hw/fbpf_decode.sv
// Purpose: decode the protect code against a target block
// Assumes: inputs stable in the cycle they are used
// Notes: purely combinational
`timescale 1ns/10ps
module fbpf_decode
	import fbpf_pkg::*;
(
	// carrier
	fbpf_if.dec bus
);
	// ==========================================
	// decode
	logic [5:0] span; // blocks-minus-one of the area
	always_comb begin
		span = 6'h00;
		bus.hit = 1'b0;
		unique case (bus.code)
			4'h0, 4'hF: bus.hit = 1'b0; // none
			4'h7, 4'h8: bus.hit = 1'b1; // all blocks
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
				// top area ending at block 63
				span = 6'((7'h01 << (bus.code - 4'h1)) - 7'h01);
				bus.hit = bus.blk >= (BLK_TOP - span);
			end
			default: begin
				// bottom area starting at block 0
				span = 6'((7'h01 << (4'hE - bus.code)) - 7'h01);
				bus.hit = bus.blk <= (BLK_BOT + span);
			end
		endcase
	end
endmodule

//--- hw/fbpf_top.sv
// Purpose: block protect decode, function register, read parameters
// Assumes: a flash command engine presents decoded requests
// Notes: outputs all registered; grants follow requests by one cycle
`timescale 1ns/10ps
// Contract
// - codes 1-6 protect top blocks to 63
// - codes 9-14 bottom; 7,8 all; 0,15 none
// - block program or erase into protected area
// - chip erase only when code is zero
// - reset-pin disable bit set once only
// - disabled dedicated pin; use shared pin
// - program suspend flag set and cleared
// - erase suspend flag set and cleared
// - row lock bits refuse row programming
// - otp bits never return to zero except on RST_IN, which loads FN_RESET
// - read parameters kept nonvolatile and volatile
// - power-up loads volatile from nonvolatile
module fbpf_top
	import fbpf_pkg::*;
#(
	parameter logic RST_DIS_INIT = 1'b0 // part-variant strap value
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// protect code from the status register
	input wire logic [3:0] PROT_CODE_IN,
	// operation request
	input wire logic REQ_IN,
	input wire logic [1:0] REQ_OP_IN,
	input wire logic [5:0] REQ_BLK_IN,
	input wire logic [1:0] REQ_ROW_IN,
	// function register write
	input wire logic FN_WR_IN,
	input wire logic [7:0] FN_WDATA_IN,
	// suspend and resume events
	input wire logic SUSPEND_IN,
	input wire logic RESUME_IN,
	input wire logic PROG_BUSY_IN,
	input wire logic ERASE_BUSY_IN,
	// read parameter writes
	input wire logic RP_NV_WR_IN,
	input wire logic RP_V_WR_IN,
	input wire logic ERP_NV_WR_IN,
	input wire logic ERP_V_WR_IN,
	input wire logic [7:0] RP_WDATA_IN,
	// reset pins, from outside
	input wire logic DED_RST_N_IN,
	input wire logic SHR_RST_N_IN,
	// answers
	output logic GRANT_OUT,
	output logic DENY_OUT,
	output logic [7:0] FN_RDATA_OUT,
	output logic [7:0] RP_VOL_OUT,
	output logic [7:0] ERP_VOL_OUT,
	output logic [7:0] RP_NV_OUT,
	output logic [7:0] ERP_NV_OUT,
	output logic PIN_RESET_OUT
);
	// ==========================================
	// decoder
	fbpf_if pif();
	assign pif.code = PROT_CODE_IN;
	assign pif.blk = REQ_BLK_IN;
	fbpf_decode u_dec (
		.bus(pif.dec)
	);

	// ==========================================
	// request judgement
	logic grant_reg, grant_next;
	logic deny_reg, deny_next;
	logic [7:0] fn_reg, fn_next;
	logic row_locked;
	always_comb begin
		row_locked = fn_reg[FN_LOCK_LO + 32'(REQ_ROW_IN)];
		grant_next = 1'b0;
		deny_next = 1'b0;
		if (REQ_IN) begin
			unique case (fbpf_op_t'(REQ_OP_IN))
				FBPF_OP_PROG, FBPF_OP_ERASE:
					deny_next = pif.hit;
				FBPF_OP_CHIP:
					deny_next = (PROT_CODE_IN != 4'h0);
				FBPF_OP_ROW:
					deny_next = row_locked;
			endcase
			grant_next = ~deny_next;
		end
	end

	// ==========================================
	// function register next value
	logic strap_done_reg, strap_done_next;
	logic [7:0] otp_wr;
	always_comb begin
		fn_next = fn_reg;
		otp_wr = FN_WDATA_IN & FN_OTP_MASK;
		strap_done_next = 1'b1;
		// strap caught on the first clock after reset release
		if (!strap_done_reg)
			fn_next[FN_RST_DIS] = RST_DIS_INIT;
		else if (FN_WR_IN)
			fn_next = fn_reg | otp_wr;
		// suspend flags: set wins over clear
		if (RESUME_IN)
			fn_next[FN_PROGRAM_SUSPENDED_FLAG] = 1'b0;
		if (SUSPEND_IN && PROG_BUSY_IN)
			fn_next[FN_PROGRAM_SUSPENDED_FLAG] = 1'b1;
		if (RESUME_IN)
			fn_next[FN_ERASE_SUSPENDED_FLAG] = 1'b0;
		if (SUSPEND_IN && ERASE_BUSY_IN)
			fn_next[FN_ERASE_SUSPENDED_FLAG] = 1'b1;
		fn_next[FN_RSVD] = 1'b0;
	end

	// ==========================================
	// read parameter pairs
	logic [7:0] rp_nv_reg, rp_nv_next, rp_v_reg, rp_v_next;
	logic [7:0] erp_nv_reg, erp_nv_next, erp_v_reg, erp_v_next;
	always_comb begin
		rp_nv_next = RP_NV_WR_IN ? RP_WDATA_IN : rp_nv_reg;
		erp_nv_next = ERP_NV_WR_IN ? RP_WDATA_IN : erp_nv_reg;
		rp_v_next = RP_V_WR_IN ? RP_WDATA_IN : rp_v_reg;
		erp_v_next = ERP_V_WR_IN ? RP_WDATA_IN : erp_v_reg;
		if (!strap_done_reg) begin
			rp_v_next = rp_nv_reg;
			erp_v_next = erp_nv_reg;
		end
	end

	// ==========================================
	// reset pin synchronisers and selection
	logic [1:0] ded_sync_reg, shr_sync_reg;
	logic pin_rst_reg, pin_rst_next;
	always_comb begin
		// active when selected pin is low
		if (fn_reg[FN_RST_DIS])
			pin_rst_next = ~shr_sync_reg[1];
		else
			pin_rst_next = ~ded_sync_reg[1];
	end

	// ==========================================
	// registers
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			grant_reg <= 1'b0;
			deny_reg <= 1'b0;
			fn_reg <= FN_RESET;
			strap_done_reg <= 1'b0;
			rp_nv_reg <= RDPAR_RESET;
			erp_nv_reg <= RDPAR_RESET;
			rp_v_reg <= RDPAR_RESET;
			erp_v_reg <= RDPAR_RESET;
			ded_sync_reg <= 2'b11;
			shr_sync_reg <= 2'b11;
			pin_rst_reg <= 1'b0;
		end else begin
			grant_reg <= grant_next;
			deny_reg <= deny_next;
			fn_reg <= fn_next;
			strap_done_reg <= strap_done_next;
			rp_nv_reg <= rp_nv_next;
			erp_nv_reg <= erp_nv_next;
			rp_v_reg <= rp_v_next;
			erp_v_reg <= erp_v_next;
			ded_sync_reg <= {ded_sync_reg[0], DED_RST_N_IN};
			shr_sync_reg <= {shr_sync_reg[0], SHR_RST_N_IN};
			pin_rst_reg <= pin_rst_next;
		end
	end

	// ==========================================
	// outputs
	assign GRANT_OUT = grant_reg;
	assign DENY_OUT = deny_reg;
	assign FN_RDATA_OUT = fn_reg;
	assign RP_VOL_OUT = rp_v_reg;
	assign ERP_VOL_OUT = erp_v_reg;
	assign RP_NV_OUT = rp_nv_reg;
	assign ERP_NV_OUT = erp_nv_reg;
	assign PIN_RESET_OUT = pin_rst_reg;

	// ==========================================
	// assertions
	AST_CHIP_DENY: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_CHIP) && PROT_CODE_IN != 4'h0
		|=> DENY_OUT && !GRANT_OUT)
		else $error("chip erase not refused");
	AST_TOP_AREA: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_ERASE) && PROT_CODE_IN == 4'h1
		&& REQ_BLK_IN == 6'h3F |=> DENY_OUT)
		else $error("block 63 not protected");
	AST_TOP_EDGE: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_PROG) && PROT_CODE_IN == 4'h6
		&& REQ_BLK_IN == 6'h1F |=> GRANT_OUT)
		else $error("block 31 wrongly protected");
	AST_BOT_AREA: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_PROG) && PROT_CODE_IN == 4'h9
		|=> DENY_OUT == ($past(REQ_BLK_IN) < 6'h20))
		else $error("bottom area wrong");
	AST_ROW_LOCK: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_ROW) |=>
		DENY_OUT == $past(fn_reg[FN_LOCK_LO + 32'(REQ_ROW_IN)]))
		else $error("row lock not applied");
	// otp bits: old ones kept, written ones added, nothing else
	AST_OTP_STICKY: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		strap_done_reg |=> (FN_RDATA_OUT & FN_OTP_MASK) ==
		(($past(FN_RDATA_OUT) | ($past(FN_WR_IN) ? $past(FN_WDATA_IN)
		: 8'h00)) & FN_OTP_MASK))
		else $error("otp bit lost or wrongly set");
	AST_PROGRAM_SUSPENDED_FLAG_SET: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		SUSPEND_IN && PROG_BUSY_IN |=> FN_RDATA_OUT[FN_PROGRAM_SUSPENDED_FLAG])
		else $error("program suspend flag not set");
	AST_ERASE_SUSPENDED_FLAG_CLR: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		RESUME_IN && !(SUSPEND_IN && ERASE_BUSY_IN)
		|=> !FN_RDATA_OUT[FN_ERASE_SUSPENDED_FLAG])
		else $error("erase suspend flag not cleared");
	AST_RSVD_ZERO: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		##1 !FN_RDATA_OUT[FN_RSVD])
		else $error("reserved bit set");
	AST_PWRUP_LOAD: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		!strap_done_reg |=> RP_VOL_OUT == $past(rp_nv_reg)
		&& ERP_VOL_OUT == $past(erp_nv_reg))
		else $error("volatile copy not loaded");
	AST_PIN_SEL: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		fn_reg[FN_RST_DIS] && shr_sync_reg[1] |=> !PIN_RESET_OUT)
		else $error("shared reset pin not honoured");
	COV_CHIP_OK: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		REQ_IN && REQ_OP_IN == 2'(FBPF_OP_CHIP) ##1 GRANT_OUT);
	COV_SUSPEND: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		FN_RDATA_OUT[FN_PROGRAM_SUSPENDED_FLAG] ##[1:20] !FN_RDATA_OUT[FN_PROGRAM_SUSPENDED_FLAG]);
	COV_LOCK: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		FN_WR_IN && FN_WDATA_IN[FN_LOCK_LO] ##1 FN_RDATA_OUT[FN_LOCK_LO]);
endmodule

//--- verif/fbpf_host.sv
// Purpose: host side issuing decoded flash requests
// Assumes: requests launched just after a rising edge
// Notes: released block lines are scrambled, not held
`timescale 1ns/10ps
module fbpf_host
	import fbpf_pkg::*;
(
	// clock
	input wire logic clk_in,
	// request lines
	output logic req_out,
	output logic [1:0] op_out,
	output logic [5:0] blk_out,
	output logic [1:0] row_out
);
	// ==========================================
	// idle values at time zero
	initial begin
		req_out = 1'b0;
		op_out = 2'h0;
		blk_out = 6'h00;
		row_out = 2'h0;
	end
	// one request, held over the sampling edge
	task automatic issue(input fbpf_op_t op, input logic [5:0] b,
		input logic [1:0] r);
		@(posedge clk_in);
		req_out <= 1'b1;
		op_out <= op;
		blk_out <= b;
		row_out <= r;
		@(posedge clk_in);
		req_out <= 1'b0;
		blk_out <= ~b; // released lines show the inverse
		row_out <= ~r;
	endtask
endmodule

//--- verif/flash_block_protect_and_function_reg_test.sv
// Purpose: self-checking bench for the protect and function register
// Assumes: answers one cycle after a request
// Notes: strobes drive all write and suspend pulses
`timescale 1ns/10ps
`define CHK(n, e, g) checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end
module flash_block_protect_and_function_reg_test
	import fbpf_pkg::*;
;
	// ==========================================
	// stimulus and observed signals
	logic clk = 1'b0, rst = 1'b1, pb = 1'b0, eb = 1'b0;
	logic dn = 1'b1, sn = 1'b1;
	logic [3:0] code = 4'h0;
	logic [6:0] st = 7'h00; // one-hot strobes
	logic [7:0] wd = 8'h00;
	logic req, grant, deny, pin;
	logic [1:0] op, row;
	logic [5:0] blk;
	logic [7:0] fn, rpv, erpv, rpn, erpn;
	int bad_count = 0, checks = 0;
	always #25 clk = ~clk;
	fbpf_host host_u (.clk_in(clk), .req_out(req), .op_out(op),
		.blk_out(blk), .row_out(row));
	fbpf_top #(.RST_DIS_INIT(1'b0)) dut_u (.CLK_IN(clk), .RST_IN(rst),
		.PROT_CODE_IN(code), .REQ_IN(req), .REQ_OP_IN(op),
		.REQ_BLK_IN(blk), .REQ_ROW_IN(row), .FN_WR_IN(st[0]),
		.FN_WDATA_IN(wd), .SUSPEND_IN(st[1]), .RESUME_IN(st[2]),
		.PROG_BUSY_IN(pb), .ERASE_BUSY_IN(eb), .RP_NV_WR_IN(st[3]),
		.RP_V_WR_IN(st[4]), .ERP_NV_WR_IN(st[5]), .ERP_V_WR_IN(st[6]),
		.RP_WDATA_IN(wd), .DED_RST_N_IN(dn), .SHR_RST_N_IN(sn),
		.GRANT_OUT(grant), .DENY_OUT(deny), .FN_RDATA_OUT(fn),
		.RP_VOL_OUT(rpv), .ERP_VOL_OUT(erpv), .RP_NV_OUT(rpn),
		.ERP_NV_OUT(erpn), .PIN_RESET_OUT(pin));
	// ==========================================
	// expected protection of a block under a code
	function automatic logic prot(input logic [3:0] c, input int b);
		if (c inside {[1:6]}) return b >= 64 - (1 << (c - 1));
		if (c inside {[9:14]}) return b < (1 << (14 - c));
		return c == 4'h7 || c == 4'h8;
	endfunction
	task automatic give_verdict();
		if (bad_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic reset_seq();
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// one request and its one-cycle answer
	task automatic ask(input fbpf_op_t o, input logic [5:0] b,
		input logic [1:0] r, input logic g);
		host_u.issue(o, b, r);
		// answer stands for the one cycle after the sampling edge
		#1;
		`CHK("grant", g, grant)
		`CHK("deny", !g, deny)
	endtask
	// pulse strobe k with data d, settle one cycle
	task automatic strobe(input int k, input logic [7:0] d);
		@(posedge clk);
		wd <= d;
		st <= 7'h01 << k;
		@(posedge clk);
		st <= 7'h00;
		@(posedge clk);
		#1;
	endtask
	task automatic pins(input logic d, input logic s, input logic e);
		@(posedge clk);
		dn <= d;
		sn <= s;
		repeat (5) @(posedge clk);
		#1;
		`CHK("pin", e, pin)
	endtask
	// watchdog
	initial begin
		repeat (50000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		reset_seq();
		`CHK("fn", 8'h00, fn)
		for (int c = 0; c < 16; c++) begin
			@(posedge clk);
			code <= 4'(c);
			for (int i = 0; i < 64; i++) begin
				ask(i[0] ? FBPF_OP_ERASE : FBPF_OP_PROG, 6'(i), 2'h0,
					!prot(4'(c), i));
			end
			ask(FBPF_OP_CHIP, 6'h00, 2'h0, c == 0);
		end
		@(posedge clk);
		code <= 4'h0;
		strobe(0, 8'h20);
		`CHK("fn", 8'h20, fn)
		for (int r = 0; r < 4; r++) begin
			ask(FBPF_OP_ROW, 6'h00, 2'(r), r != 1);
		end
		strobe(0, 8'h00);
		`CHK("fn", 8'h20, fn)
		strobe(0, 8'h0E);
		`CHK("fn", 8'h20, fn)
		pins(1'b0, 1'b1, 1'b1);
		pins(1'b1, 1'b0, 1'b0);
		strobe(0, 8'h01);
		`CHK("fn", 8'h21, fn)
		// bit 0 now set: a write of zero must not clear it
		strobe(0, 8'h00);
		`CHK("fn", 8'h21, fn)
		pins(1'b1, 1'b0, 1'b1);
		pins(1'b0, 1'b1, 1'b0);
		pb <= 1'b1;
		strobe(1, 8'h00);
		`CHK("fn", 8'h25, fn)
		strobe(2, 8'h00);
		`CHK("fn", 8'h21, fn)
		pb <= 1'b0;
		eb <= 1'b1;
		strobe(1, 8'h00);
		`CHK("fn", 8'h29, fn)
		strobe(2, 8'h00);
		`CHK("fn", 8'h21, fn)
		eb <= 1'b0;
		strobe(3, 8'hA5);
		strobe(5, 8'h5A);
		strobe(4, 8'h3C);
		strobe(6, 8'hC3);
		`CHK("rpn", 8'hA5, rpn)
		`CHK("erpn", 8'h5A, erpn)
		`CHK("rpv", 8'h3C, rpv)
		`CHK("erpv", 8'hC3, erpv)
		// reset clears the stored copies too, so the load brings reset values
		reset_seq();
		`CHK("rpv", RDPAR_RESET, rpv)
		`CHK("erpv", RDPAR_RESET, erpv)
		give_verdict();
	end
endmodule
